// ---- timer_pkg.sv ----
// Purpose: Shared constants and types for the reload/capture timer
// Assumes: 8-bit register port, one clock domain
// Notes: Register addresses sit in an 8-bit space
package timer_pkg;
    // ==========================================================
    // Widths and plain values
    localparam int BYTE_W = 8;
    localparam int ADDR_W = 8;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] BYTE_MAX = 8'hFF;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    // ==========================================================
    // Register addresses
    localparam logic [7:0] ADDR_CTRL = 8'h91;
    localparam logic [7:0] ADDR_RLD_LO = 8'h92;
    localparam logic [7:0] ADDR_RLD_HI = 8'h93;
    localparam logic [7:0] ADDR_CNT_LO = 8'h94;
    localparam logic [7:0] ADDR_CNT_HI = 8'h95;
    localparam logic [7:0] ADDR_CFG = 8'h96;
    // ==========================================================
    // Control register fields
    localparam int CTL_HI_FLAG = 7;
    localparam int CTL_LO_FLAG = 6;
    localparam int CTL_LO_IRQ_EN = 5;
    localparam int CTL_CAP_EN = 4;
    localparam int CTL_SPLIT = 3;
    localparam int CTL_RUN = 2;
    localparam int CTL_CAP_SRC = 1;
    localparam int CTL_EXT_CLK = 0;
    // ==========================================================
    // Configuration register fields
    localparam int CFG_LO_CLK_SEL = 0;
    localparam int CFG_HI_CLK_SEL = 1;
    localparam int CFG_IRQ_EN = 2;
    localparam int CFG_USED_W = 3;
    // ==========================================================
    // Clock dividers
    localparam int SYS_DIV = 12;
    localparam int EXT_DIV = 8;
    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        MODE_RELOAD16,
        MODE_SPLIT8,
        MODE_CAP16,
        MODE_CAP8
    } mode_t;
endpackage

// ---- tick_if.sv ----
// Purpose: Carries prescaled count ticks between modules
// Assumes: Ticks are one-cycle pulses on clk
// Notes: Source drives, timer core listens
`timescale 1ns/1ps
interface tick_if;
    logic div12_tick;
    logic ext8_tick;
    modport src (
        output div12_tick,
        output ext8_tick
    );
    modport sink (
        input div12_tick,
        input ext8_tick
    );
endinterface

// ---- tick_gen.sv ----
// Purpose: Makes system/12 and external/8 count ticks
// Assumes: ext_clk_in is slower than half of clk
// Notes: Ticks are single-cycle pulses
`timescale 1ns/1ps
module tick_gen #(
    parameter int SYS_DIV = timer_pkg::SYS_DIV,
    parameter int EXT_DIV = timer_pkg::EXT_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ext_clk_in,
    tick_if.src ticks
);
    localparam int SW = $clog2(SYS_DIV);
    localparam int EW = $clog2(EXT_DIV);
    localparam logic [SW-1:0] SYS_LAST = SW'(SYS_DIV - 1);
    localparam logic [EW-1:0] EXT_LAST = EW'(EXT_DIV - 1);
    // ==========================================================
    // Elaboration check
    if (SYS_DIV < 2 || EXT_DIV < 2) begin : g_bad_div
        $error("tick_gen: dividers must be at least 2");
    end
    logic [SW-1:0] sys_cnt_ff;
    logic [EW-1:0] ext_cnt_ff;
    logic ext_meta_ff;
    logic ext_sync_ff;
    logic ext_prev_ff;
    logic div12_ff;
    logic ext8_ff;
    wire sys_wrap = (sys_cnt_ff == SYS_LAST);
    wire ext_rise = ext_sync_ff & ~ext_prev_ff;
    wire ext_wrap = ext_rise & (ext_cnt_ff == EXT_LAST);
    // ==========================================================
    // System clock prescaler
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sys_cnt_ff <= '0;
            div12_ff <= 1'b0;
        end else begin
            sys_cnt_ff <= sys_wrap ? '0 : SW'(sys_cnt_ff + 1'b1);
            div12_ff <= sys_wrap;
        end
    end
    // ==========================================================
    // External clock: two-flop sync, then divide rising edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta_ff <= 1'b0;
            ext_sync_ff <= 1'b0;
            ext_prev_ff <= 1'b0;
            ext_cnt_ff <= '0;
            ext8_ff <= 1'b0;
        end else begin
            ext_meta_ff <= ext_clk_in;
            ext_sync_ff <= ext_meta_ff;
            ext_prev_ff <= ext_sync_ff;
            // Wrap on purpose so dividers that are not powers of two work
            if (ext_rise) begin
                ext_cnt_ff <= ext_wrap ? '0 : EW'(ext_cnt_ff + 1'b1);
            end
            ext8_ff <= ext_wrap;
        end
    end
    assign ticks.div12_tick = div12_ff;
    assign ticks.ext8_tick = ext8_ff;
endmodule // tick_gen

// ---- reload_capture_timer.sv ----
// Purpose: 16-bit reload/capture timer with split 8-bit mode
// Assumes: Inputs synchronous to clk except ext_clk_in
// Notes: Register reads answer one cycle after rd_en
//
// The implementer's own choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
module reload_capture_timer #(
    parameter int SYS_DIV = timer_pkg::SYS_DIV,
    parameter int EXT_DIV = timer_pkg::EXT_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [timer_pkg::ADDR_W-1:0] addr,
    input wire logic [timer_pkg::BYTE_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic ext_clk_in,
    input wire logic usb_sof,
    input wire logic lfo_in,
    output logic [timer_pkg::BYTE_W-1:0] rd_data_ff,
    output logic irq_ff
);
    localparam int BW = timer_pkg::BYTE_W;
    // Smallest divider the tick counters can wrap at
    localparam int MIN_DIV = 2;

    // ==========================================================
    // Elaboration checks
    if (SYS_DIV < MIN_DIV) begin : g_bad_sys_div
        $error("reload_capture_timer: SYS_DIV below the minimum");
    end
    if (EXT_DIV < MIN_DIV) begin : g_bad_ext_div
        $error("reload_capture_timer: EXT_DIV below the minimum");
    end
    // Byte masks and register addresses are fixed at eight bits
    if (timer_pkg::BYTE_W != $bits(timer_pkg::BYTE_MAX) ||
        timer_pkg::ADDR_W != $bits(timer_pkg::ADDR_CTRL)) begin : g_bad_w
        $error("reload_capture_timer: byte and address must be 8 bits");
    end

    // ==========================================================
    // State
    logic [BW-1:0] timer_control_reg_ff;
    logic [BW-1:0] cfg_ff;
    logic [BW-1:0] count_low_byte_ff;
    logic [BW-1:0] count_high_byte_ff;
    logic [BW-1:0] reload_low_byte_ff;
    logic [BW-1:0] reload_high_byte_ff;
    logic lfo_prev_ff;

    logic [BW-1:0] nxt_control;
    logic [BW-1:0] nxt_cfg;
    logic [BW-1:0] nxt_cnt_lo;
    logic [BW-1:0] nxt_cnt_hi;
    logic [BW-1:0] nxt_rld_lo;
    logic [BW-1:0] nxt_rld_hi;
    logic [BW-1:0] nxt_rd_data;
    logic nxt_irq;

    logic lo_ovf;
    logic hi_ovf;
    logic [BW-1:0] run_lo;
    logic [BW-1:0] run_hi;

    // ==========================================================
    // Prescaled ticks
    tick_if ticks ();

    tick_gen #(
        .SYS_DIV(SYS_DIV),
        .EXT_DIV(EXT_DIV)
    ) i_tick_gen (
        .clk(clk),
        .rst_n(rst_n),
        .ext_clk_in(ext_clk_in),
        .ticks(ticks.src)
    );

    // ==========================================================
    // Address decode
    wire sel_ctrl = (addr == timer_pkg::ADDR_CTRL);
    wire sel_rld_lo = (addr == timer_pkg::ADDR_RLD_LO);
    wire sel_rld_hi = (addr == timer_pkg::ADDR_RLD_HI);
    wire sel_cnt_lo = (addr == timer_pkg::ADDR_CNT_LO);
    wire sel_cnt_hi = (addr == timer_pkg::ADDR_CNT_HI);
    wire sel_cfg = (addr == timer_pkg::ADDR_CFG);

    wire wr_ctrl = wr_en & sel_ctrl;
    wire wr_rld_lo = wr_en & sel_rld_lo;
    wire wr_rld_hi = wr_en & sel_rld_hi;
    wire wr_cnt_lo = wr_en & sel_cnt_lo;
    wire wr_cnt_hi = wr_en & sel_cnt_hi;
    wire wr_cfg = wr_en & sel_cfg;

    // ==========================================================
    // Control fields
    wire hi_flag = timer_control_reg_ff[timer_pkg::CTL_HI_FLAG];
    wire lo_flag = timer_control_reg_ff[timer_pkg::CTL_LO_FLAG];
    wire low_byte_irq_enable =
        timer_control_reg_ff[timer_pkg::CTL_LO_IRQ_EN];
    wire capture_enable_bit =
        timer_control_reg_ff[timer_pkg::CTL_CAP_EN];
    wire split_mode_bit = timer_control_reg_ff[timer_pkg::CTL_SPLIT];
    wire run_control_bit = timer_control_reg_ff[timer_pkg::CTL_RUN];
    wire capture_source_select =
        timer_control_reg_ff[timer_pkg::CTL_CAP_SRC];
    wire external_clock_select =
        timer_control_reg_ff[timer_pkg::CTL_EXT_CLK];

    wire low_byte_clock_select = cfg_ff[timer_pkg::CFG_LO_CLK_SEL];
    wire high_byte_clock_select = cfg_ff[timer_pkg::CFG_HI_CLK_SEL];
    wire timer_irq_enable = cfg_ff[timer_pkg::CFG_IRQ_EN];

    // ==========================================================
    // Per-byte count tick; index 0 is the low byte
    wire [1:0] byte_clk_sel = {high_byte_clock_select,
                               low_byte_clock_select};
    wire slow_tick = external_clock_select ? ticks.ext8_tick
                                           : ticks.div12_tick;
    logic [1:0] byte_tick;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_byte_tick
            assign byte_tick[gi] = byte_clk_sel[gi] | slow_tick;
        end
    endgenerate

    // ==========================================================
    // Mode decode
    timer_pkg::mode_t mode;

    // Capture enable decides first; split then picks 8 or 16 bits
    assign mode = capture_enable_bit
        ? (split_mode_bit ? timer_pkg::MODE_CAP8
                          : timer_pkg::MODE_CAP16)
        : (split_mode_bit ? timer_pkg::MODE_SPLIT8
                          : timer_pkg::MODE_RELOAD16);

    // The whole 16-bit counter follows the low byte's clock
    wire step16 = run_control_bit & byte_tick[0];
    wire step_lo8 = byte_tick[0];
    wire step_hi8 = run_control_bit & byte_tick[1];

    // Wrap detect looks at the value the step starts from
    wire lo_max = (count_low_byte_ff == timer_pkg::BYTE_MAX);
    wire hi_max = (count_high_byte_ff == timer_pkg::BYTE_MAX);
    wire [BW-1:0] inc_lo = count_low_byte_ff + timer_pkg::BYTE_ONE;
    wire [BW-1:0] inc_hi = count_high_byte_ff + timer_pkg::BYTE_ONE;

    // ==========================================================
    // Capture trigger
    wire lfo_fall = lfo_prev_ff & ~lfo_in;
    wire cap_trig = capture_source_select ? lfo_fall
                                          : usb_sof;
    wire cap_evt = capture_enable_bit & cap_trig;

    // ==========================================================
    // Counting per mode
    always_comb begin
        run_lo = count_low_byte_ff;
        run_hi = count_high_byte_ff;
        lo_ovf = 1'b0;
        hi_ovf = 1'b0;
        case (mode)
            timer_pkg::MODE_RELOAD16: begin
                if (step16) begin
                    lo_ovf = lo_max;
                    hi_ovf = lo_max & hi_max;
                    if (lo_max && hi_max) begin
                        run_lo = reload_low_byte_ff;
                        run_hi = reload_high_byte_ff;
                    end else begin
                        run_lo = inc_lo;
                        if (lo_max) begin
                            run_hi = inc_hi;
                        end
                    end
                end
            end
            // Reload bytes hold the last capture, so never reload here
            timer_pkg::MODE_CAP16: begin
                if (step16) begin
                    lo_ovf = lo_max;
                    hi_ovf = lo_max & hi_max;
                    run_lo = inc_lo;
                    if (lo_max) begin
                        run_hi = inc_hi;
                    end
                end
            end
            timer_pkg::MODE_SPLIT8: begin
                if (step_lo8) begin
                    lo_ovf = lo_max;
                    run_lo = lo_max ? reload_low_byte_ff
                                    : inc_lo;
                end
                if (step_hi8) begin
                    hi_ovf = hi_max;
                    run_hi = hi_max ? reload_high_byte_ff
                                    : inc_hi;
                end
            end
            timer_pkg::MODE_CAP8: begin
                if (step_lo8) begin
                    lo_ovf = lo_max;
                    run_lo = inc_lo;
                end
                if (step_hi8) begin
                    hi_ovf = hi_max;
                    run_hi = inc_hi;
                end
            end
            default: begin
                run_lo = count_low_byte_ff;
                run_hi = count_high_byte_ff;
            end
        endcase
    end

    // ==========================================================
    // Next register values
    // A software write to a count byte beats the count step
    assign nxt_cnt_lo = wr_cnt_lo ? wr_data : run_lo;
    assign nxt_cnt_hi = wr_cnt_hi ? wr_data : run_hi;

    // Capture wins over a same-cycle software reload write
    assign nxt_rld_lo = cap_evt ? count_low_byte_ff
                      : (wr_rld_lo ? wr_data : reload_low_byte_ff);
    assign nxt_rld_hi = cap_evt ? count_high_byte_ff
                      : (wr_rld_hi ? wr_data : reload_high_byte_ff);

    // Flags: a hardware set wins over a software clear
    wire [BW-1:0] ctrl_base = wr_ctrl ? wr_data
                                      : timer_control_reg_ff;
    wire hi_set = hi_ovf | cap_evt;
    wire lo_set = lo_ovf;

    always_comb begin
        nxt_control = ctrl_base;
        nxt_control[timer_pkg::CTL_HI_FLAG] =
            ctrl_base[timer_pkg::CTL_HI_FLAG] | hi_set;
        nxt_control[timer_pkg::CTL_LO_FLAG] =
            ctrl_base[timer_pkg::CTL_LO_FLAG] | lo_set;
    end

    // Unused configuration bits read as zero
    always_comb begin
        nxt_cfg = cfg_ff;
        if (wr_cfg) begin
            nxt_cfg = timer_pkg::RST_BYTE;
            nxt_cfg[timer_pkg::CFG_USED_W-1:0] =
                wr_data[timer_pkg::CFG_USED_W-1:0];
        end
    end

    // ==========================================================
    // Interrupt request: level, follows the flags one cycle later
    wire lo_req = low_byte_irq_enable & lo_flag;
    assign nxt_irq = timer_irq_enable & (hi_flag | lo_req);

    // ==========================================================
    // Read mux; unmapped addresses read zero
    assign nxt_rd_data =
        !rd_en ? timer_pkg::RST_BYTE
      : sel_ctrl ? timer_control_reg_ff
      : sel_rld_lo ? reload_low_byte_ff
      : sel_rld_hi ? reload_high_byte_ff
      : sel_cnt_lo ? count_low_byte_ff
      : sel_cnt_hi ? count_high_byte_ff
      : sel_cfg ? cfg_ff
      : timer_pkg::RST_BYTE;

    // ==========================================================
    // Registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_control_reg_ff <= timer_pkg::RST_BYTE;
            cfg_ff <= timer_pkg::RST_BYTE;
        end else begin
            timer_control_reg_ff <= nxt_control;
            cfg_ff <= nxt_cfg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_low_byte_ff <= timer_pkg::RST_BYTE;
            count_high_byte_ff <= timer_pkg::RST_BYTE;
        end else begin
            count_low_byte_ff <= nxt_cnt_lo;
            count_high_byte_ff <= nxt_cnt_hi;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_low_byte_ff <= timer_pkg::RST_BYTE;
            reload_high_byte_ff <= timer_pkg::RST_BYTE;
        end else begin
            reload_low_byte_ff <= nxt_rld_lo;
            reload_high_byte_ff <= nxt_rld_hi;
        end
    end

    // Oscillator level reset high, so a low lfo_in just after reset reads as a falling edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lfo_prev_ff <= 1'b1;
        end else begin
            lfo_prev_ff <= lfo_in;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_ff <= timer_pkg::RST_BYTE;
            irq_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            irq_ff <= nxt_irq;
        end
    end
endmodule // reload_capture_timer

// ---- reload_capture_timer_sva.sv ----
// Purpose: Port checker for the reload/capture timer
// Assumes: One clock, rst_n async active low
// Notes: Counting is unseen at the ports; bus relations only
`timescale 1ns/1ps
module timer_chk #(
    parameter int SYS_DIV = timer_pkg::SYS_DIV,
    parameter int EXT_DIV = timer_pkg::EXT_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic usb_sof,
    input wire logic lfo_in,
    input wire logic [7:0] rd_data_ff,
    input wire logic irq_ff
);
    // ====================
    // Decode
    wire logic rd_ct = rd_en && addr == timer_pkg::ADDR_CTRL;
    wire logic wr_ct = wr_en && addr == timer_pkg::ADDR_CTRL;
    wire logic rd_cf = rd_en && addr == timer_pkg::ADDR_CFG;
    wire logic wr_cf = wr_en && addr == timer_pkg::ADDR_CFG;
    // A capture may overwrite reload, so only quiet event inputs count
    wire logic calm = !usb_sof && lfo_in;
    wire logic rd_rl = rd_en && addr == timer_pkg::ADDR_RLD_LO && calm;
    wire logic wr_rl = wr_en && addr == timer_pkg::ADDR_RLD_LO && calm;
    wire logic mapped = addr >= timer_pkg::ADDR_CTRL &&
        addr <= timer_pkg::ADDR_CFG;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ====================
    // Assertions
    AST_RD_IDLE: assert property (!rd_en |=> rd_data_ff == 8'h00)
        else $error("read data not zero when idle");
    AST_RD_UNMAPPED: assert property (
        rd_en && !mapped |=> rd_data_ff == 8'h00)
        else $error("unmapped read not zero");
    AST_CFG_RB: assert property (wr_cf ##1 !wr_en ##1 rd_cf |=>
        rd_data_ff == ($past(wr_data, 3) & 8'h07))
        else $error("config read back wrong");
    AST_CTRL_RB: assert property (wr_ct ##1 !wr_en ##1 rd_ct |=>
        (rd_data_ff & 8'h3F) == ($past(wr_data, 3) & 8'h3F))
        else $error("control read back wrong");
    AST_RLD_RB: assert property (
        wr_rl ##1 (!wr_en && calm) ##1 rd_rl |=>
        rd_data_ff == $past(wr_data, 3))
        else $error("reload read back wrong");
    AST_FLAG_STICKY: assert property (rd_ct ##1 !wr_en ##1 rd_ct |=>
        (rd_data_ff & $past(rd_data_ff, 2) & 8'hC0) ==
        ($past(rd_data_ff, 2) & 8'hC0))
        else $error("flag dropped without write");
    AST_IRQ_OFF: assert property (
        wr_cf && !wr_data[2] |-> ##2 !irq_ff)
        else $error("irq high with enable off");
    AST_IRQ_HOLD: assert property (
        irq_ff && !wr_en && !$past(wr_en) |=> irq_ff)
        else $error("irq fell without write");
    AST_RST_QUIET: assert property (
        $rose(rst_n) |-> !irq_ff && rd_data_ff == 8'h00)
        else $error("outputs busy after reset");
    // ====================
    // Cover
    COV_IRQ: cover property ($rose(irq_ff));
    COV_STICKY: cover property (rd_ct ##1 rd_data_ff[7] ##1 rd_ct);
    COV_UNMAPPED: cover property (rd_en && !mapped);
endmodule // timer_chk

bind reload_capture_timer timer_chk #(
    .SYS_DIV(SYS_DIV),
    .EXT_DIV(EXT_DIV)
) i_timer_chk (
    .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .usb_sof(usb_sof), .lfo_in(lfo_in),
    .rd_data_ff(rd_data_ff), .irq_ff(irq_ff)
);

// ---- reload_capture_timer_bench.sv ----
// Purpose: Self-checking bench for the reload/capture timer
// Assumes: Byte clocks on clk except in the divider tests
// Notes: Divided counts get slack, since tick phase is free
`timescale 1ns/1ps
module reload_capture_timer_bench;
    localparam logic [7:0] CT = timer_pkg::ADDR_CTRL;
    localparam logic [7:0] RL = timer_pkg::ADDR_RLD_LO;
    localparam logic [7:0] RH = timer_pkg::ADDR_RLD_HI;
    localparam logic [7:0] CL = timer_pkg::ADDR_CNT_LO;
    localparam logic [7:0] CH = timer_pkg::ADDR_CNT_HI;
    localparam logic [7:0] CF = timer_pkg::ADDR_CFG;
    localparam logic [7:0] AMAP [7] = '{8'h90, CT, RL, RH, CL, CH, CF};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wr_data = 8'h00;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [1:0] ext_div = 2'h0;
    logic usb_sof = 1'b0;
    logic lfo_in = 1'b1;
    logic [7:0] rd_data_ff;
    logic irq_ff;
    logic [7:0] d;
    int errors = 0;
    int n_tests = 0;
    always #12.5 clk = ~clk;
    // External oscillator at a quarter of clk
    always @(posedge clk) ext_div <= ext_div + 2'h1;
    reload_capture_timer i_reload_capture_timer (
        .clk(clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .ext_clk_in(ext_div[1]),
        .usb_sof(usb_sof), .lfo_in(lfo_in), .rd_data_ff(rd_data_ff),
        .irq_ff(irq_ff)
    );
    // ====================
    // Tasks
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wr_data <= v;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        @(negedge clk);
        d = rd_data_ff;
    endtask
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [7:0] a,
                        input logic [7:0] e);
        rd(a);
        chk(n, e, d);
    endtask
    task automatic sof();
        @(posedge clk);
        usb_sof <= 1'b1;
        @(posedge clk);
        usb_sof <= 1'b0;
    endtask
    task automatic conclude();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ====================
    // Watchdog, about twelve times the expected run
    initial begin
        cyc(6000);
        errors++;
        conclude();
    end
    // ====================
    // Tests
    initial begin
        cyc(8);
        rst_n <= 1'b1;
        foreach (AMAP[i]) rchk("reset", AMAP[i], 8'h00);
        for (int i = 2; i < 7; i++) wr(AMAP[i], 8'hA0 + 8'(i));
        wr(8'h90, 8'h55);
        for (int i = 2; i < 7; i++) begin
            rchk("rw", AMAP[i], i == 6 ? 8'h06 : 8'hA0 + 8'(i));
        end
        rchk("unmapped", 8'h90, 8'h00);
        // 16-bit reload, overflow flag and irq
        wr(CF, 8'h07);
        rchk("cfg_rb", CF, 8'h07);
        wr(RL, 8'h34);
        rchk("rld_rb", RL, 8'h34);
        wr(RH, 8'h12);
        wr(CL, 8'hFD);
        wr(CH, 8'hFF);
        wr(CT, 8'h04);
        cyc(6);
        rchk("reload16", CH, 8'h12);
        rd(CT);
        chk("hflag16", 8'h80, d & 8'h80);
        rd(CT);
        chk("hflag_hold", 8'h80, d & 8'h80);
        chk("irq16", 8'h01, {7'h00, irq_ff});
        // Low byte carry and low-byte irq
        wr(CT, 8'h00);
        wr(CL, 8'hFE);
        wr(CH, 8'h00);
        wr(CT, 8'h24);
        cyc(4);
        rchk("carry16", CH, 8'h01);
        rd(CT);
        chk("lflag16", 8'h40, d & 8'hC0);
        chk("irq_lo16", 8'h01, {7'h00, irq_ff});
        wr(CF, 8'h03);
        cyc(3);
        chk("irq_off", 8'h00, {7'h00, irq_ff});
        // Split mode: low runs alone, high gated by run
        wr(CT, 8'h00);
        wr(CF, 8'h07);
        wr(RL, 8'h50);
        wr(RH, 8'h60);
        wr(CL, 8'hF0);
        wr(CH, 8'h10);
        wr(CT, 8'h08);
        cyc(20);
        rchk("hi_gated", CH, 8'h10);
        rd(CL);
        chk("lo_reload8", 8'h50, d & 8'hF0);
        rd(CT);
        chk("flags8", 8'h40, d & 8'hC0);
        chk("irq_lo_off", 8'h00, {7'h00, irq_ff});
        wr(CT, 8'h68);
        cyc(3);
        chk("irq_lo8", 8'h01, {7'h00, irq_ff});
        wr(CT, 8'h08);
        wr(CH, 8'hFE);
        wr(CT, 8'h0C);
        cyc(4);
        rd(CH);
        chk("hi_reload8", 8'h60, d & 8'hF0);
        rd(CT);
        chk("hflag8", 8'h80, d & 8'h80);
        chk("irq_hi8", 8'h01, {7'h00, irq_ff});
        // Capture on start-of-frame, then free wrap
        wr(CT, 8'h00);
        wr(CH, 8'hAB);
        wr(CL, 8'h00);
        wr(CT, 8'h14);
        cyc(3);
        sof();
        rchk("cap_sof", RH, 8'hAB);
        rd(CT);
        chk("cap_flag", 8'h80, d & 8'h80);
        chk("cap_irq", 8'h01, {7'h00, irq_ff});
        wr(CH, 8'hFF);
        wr(CL, 8'hFE);
        cyc(4);
        rchk("cap_wrap", CH, 8'h00);
        // Oscillator source: frame ignored, falling edge only
        wr(CT, 8'h16);
        wr(CH, 8'hCD);
        sof();
        rchk("src_sel", RH, 8'hAB);
        @(posedge clk);
        lfo_in <= 1'b0;
        cyc(2);
        rchk("cap_fall", RH, 8'hCD);
        wr(CH, 8'hEE);
        @(posedge clk);
        lfo_in <= 1'b1;
        cyc(2);
        rchk("no_rise", RH, 8'hCD);
        // Split capture: both bytes wrap freely, frame latches both
        wr(CT, 8'h00);
        wr(CL, 8'hFE);
        wr(CH, 8'hFE);
        wr(CT, 8'h1C);
        rd(CT);
        chk("cap8_ctl", 8'h1C, d & 8'h3F);
        rd(CH);
        chk("cap8_wrap", 8'h00, d & 8'hF0);
        sof();
        rchk("cap8_rh", RH, 8'h03);
        rchk("cap8_rl", RL, 8'h03);
        rd(CT);
        chk("cap8_flags", 8'hC0, d & 8'hC0);
        // Divided clocks
        wr(CT, 8'h00);
        wr(CF, 8'h04);
        wr(CL, 8'h00);
        wr(CH, 8'h00);
        wr(CT, 8'h04);
        cyc(120);
        rd(CL);
        chk("div12", 8'h01, {7'h00, d >= 8'h09 && d <= 8'h0B});
        wr(CT, 8'h00);
        wr(CL, 8'h00);
        wr(CT, 8'h05);
        cyc(128);
        rd(CL);
        chk("ext8", 8'h01, {7'h00, d >= 8'h03 && d <= 8'h05});
        conclude();
    end
endmodule // reload_capture_timer_bench
